/* File: rtl/fesq_bus_cycle.sv */
// Flash bus cycle engine: one write or read cycle per request on the flash control pins.
// Assumes the flash data pins arrive asynchronously; they pass two flip-flops before use.
`default_nettype none
module fesq_bus_cycle (
  input wire logic clock,
  input wire logic rstn,
  fesq_cyc_if.engine cyc,
  output logic [fesq_pkg::ADDR_W-1:0] flashAddr,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic [fesq_pkg::DATA_W-1:0] flashDataOut,
  output logic flashDataOeN,
  input wire logic [fesq_pkg::DATA_W-1:0] flashDataIn
);
  import fesq_pkg::*;
  typedef enum logic [2:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD, CY_READ, CY_RECOVER} fesq_cy_t;
  fesq_cy_t st_q, st_d;
  logic [TCNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] dout_q, dout_d, rdata_q, rdata_d, din1_q, din2_q;
  logic ceN_q, ceN_d, oeN_q, oeN_d, weN_q, weN_d, doeN_q, doeN_d, done_q, done_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    dout_d = dout_q;
    rdata_d = rdata_q;
    ceN_d = ceN_q;
    oeN_d = oeN_q;
    weN_d = weN_q;
    doeN_d = doeN_q;
    done_d = 1'b0;
    if (cnt_q != '0) begin
      cnt_d = cnt_q - TCNT_W'(1);
    end
    case (st_q)
      CY_IDLE: begin
        if (cyc.req && !done_q) begin
          addr_d = cyc.addr;
          dout_d = cyc.wdata;
          ceN_d = 1'b0;
          if (cyc.isWrite) begin
            oeN_d = 1'b1;
            doeN_d = 1'b0;
            cnt_d = TCNT_W'(SETUP_CYC - 1);
            st_d = CY_SETUP;
          end else begin
            oeN_d = 1'b0;
            cnt_d = TCNT_W'(ACCESS_CYC + SYNC_CYC - 1);
            st_d = CY_READ;
          end
        end
      end
      CY_SETUP: begin
        if (cnt_q == '0) begin
          weN_d = 1'b0;
          cnt_d = TCNT_W'(PULSE_CYC - 1);
          st_d = CY_PULSE;
        end
      end
      CY_PULSE: begin
        if (cnt_q == '0) begin
          weN_d = 1'b1;
          cnt_d = TCNT_W'(HOLD_CYC - 1);
          st_d = CY_HOLD;
        end
      end
      CY_HOLD: begin
        if (cnt_q == '0) begin
          ceN_d = 1'b1;
          doeN_d = 1'b1;
          cnt_d = TCNT_W'(RECOVER_CYC - 1);
          st_d = CY_RECOVER;
        end
      end
      CY_READ: begin
        if (cnt_q == '0) begin
          rdata_d = din2_q;
          ceN_d = 1'b1;
          oeN_d = 1'b1;
          cnt_d = TCNT_W'(RECOVER_CYC - 1);
          st_d = CY_RECOVER;
        end
      end
      CY_RECOVER: begin
        if (cnt_q == '0) begin
          done_d = 1'b1;
          st_d = CY_IDLE;
        end
      end
      default: st_d = CY_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_q <= CY_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      dout_q <= '0;
      rdata_q <= '0;
      din1_q <= '0;
      din2_q <= '0;
      ceN_q <= 1'b1;
      oeN_q <= 1'b1;
      weN_q <= 1'b1;
      doeN_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      rdata_q <= rdata_d;
      din1_q <= flashDataIn;
      din2_q <= din1_q;
      ceN_q <= ceN_d;
      oeN_q <= oeN_d;
      weN_q <= weN_d;
      doeN_q <= doeN_d;
      done_q <= done_d;
    end
  end

  assign flashAddr = addr_q;
  assign flashCeN = ceN_q;
  assign flashOeN = oeN_q;
  assign flashWeN = weN_q;
  assign flashDataOut = dout_q;
  assign flashDataOeN = doeN_q;
  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;
endmodule : fesq_bus_cycle
`default_nettype wire

/* File: rtl/fesq_cyc_if.sv */
// Request/answer channel between the sequencer and the flash bus cycle engine.
// The master holds req until it sees done; done is a one-cycle pulse.
`default_nettype none
interface fesq_cyc_if;
  import fesq_pkg::*;
  logic req;
  logic isWrite;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport master (output req, output isWrite, output addr, output wdata, input done, input rdata);
  modport engine (input req, input isWrite, input addr, input wdata, output done, output rdata);
endinterface : fesq_cyc_if
`default_nettype wire

/* File: rtl/fesq_pkg.sv */
// Package of the flash erase/status sequencer controller: command codes, flash timing, register map.
// Assumes a single 250 MHz clock and a byte-wide flash with separate chip-select, output gate and write strobe.
`default_nettype none
package fesq_pkg;
  localparam int CLOCK_MHZ = 250;
  localparam int WINDOW_US = 80;
  localparam int WINDOW_CYCLES_DEF = WINDOW_US * CLOCK_MHZ;
  // Flash bus cycle timing, rounded up to whole clock cycles.
  localparam int T_SETUP_NS = 20;
  localparam int T_PULSE_NS = 50;
  localparam int T_HOLD_NS = 20;
  localparam int T_ACCESS_NS = 150;
  localparam int T_RECOVER_NS = 20;
  localparam int SETUP_CYC = (T_SETUP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (T_PULSE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLOCK_MHZ + 999) / 1000;
  localparam int ACCESS_CYC = (T_ACCESS_NS * CLOCK_MHZ + 999) / 1000;
  localparam int RECOVER_CYC = (T_RECOVER_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SYNC_CYC = 2;
  localparam int WRITE_CYC = SETUP_CYC + PULSE_CYC + HOLD_CYC + RECOVER_CYC;
  localparam int TCNT_W = 6;
  localparam int WCNT_W = 16;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int SECT_LSB = 14;
  localparam int SECT_N = 8;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 17'h05555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 17'h02AAA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'hA0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [DATA_W-1:0] CMD_SECTOR = 8'h30;
  localparam logic [2:0] PREFIX_LAST_SHORT = 3'h2;
  localparam logic [2:0] PREFIX_LAST_ERASE = 3'h4;
  localparam logic [2:0] SECT_LAST = 3'h7;
  localparam int POLL_BIT = 7;
  localparam int OVERTIME_BIT = 5;
  // Operations written into the control register.
  localparam logic [1:0] OP_RESET = 2'h0;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  // Register map, byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_SECT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_LATE = 3;
  localparam int ST_LOCK = 4;
  localparam int ST_WINOPEN = 5;
  localparam int ST_POLL_LSB = 8;
  localparam int ST_RDATA_LSB = 16;
endpackage : fesq_pkg
`default_nettype wire

/* File: rtl/fesq_sequencer.sv */
// Host-side controller for a byte-wide flash: issues reset, program, multi-sector erase and read sequences,
// polls completion and reports status. Software reaches it over a classic Wishbone slave.
// Assumes lockoutIn comes from a supply supervisor outside the clock domain.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`default_nettype none
// Function
// - Add sectors, each within window of previous
// - Poll inside an erased sector until done
// - Write only with select, strobe low, gate high
// - After overtime, reset sequence restores read mode
// - Reset is three writes ending with F0
// - Sector address on fall, 30 on rise
module fesq_sequencer #(
  parameter int WINDOW_CYCLES = fesq_pkg::WINDOW_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [fesq_pkg::ADDR_W-1:0] flashAddr,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic [fesq_pkg::DATA_W-1:0] flashDataOut,
  output logic flashDataOeN,
  input wire logic [fesq_pkg::DATA_W-1:0] flashDataIn,
  input wire logic lockoutIn
);
  import fesq_pkg::*;
  typedef enum logic [2:0] {ST_IDLE, ST_PREFIX, ST_PROG, ST_SECTOR, ST_POLL, ST_RESET, ST_READ} fesq_st_t;

  fesq_cyc_if cycBus ();
  logic winExpired;

  fesq_bus_cycle u_cycle (
    .clock(clock),
    .rstn(rstn),
    .cyc(cycBus.engine),
    .flashAddr(flashAddr),
    .flashCeN(flashCeN),
    .flashOeN(flashOeN),
    .flashWeN(flashWeN),
    .flashDataOut(flashDataOut),
    .flashDataOeN(flashDataOeN),
    .flashDataIn(flashDataIn)
  );

  logic restart_q, restart_d;

  fesq_window_timer #(.CYCLES(WINDOW_CYCLES)) u_window (
    .clock(clock),
    .rstn(rstn),
    .restart(restart_q),
    .expired(winExpired)
  );

  // Lockout level crosses in through two flip-flops.
  logic lock1_q, lock2_q;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lock1_q <= 1'b0;
      lock2_q <= 1'b0;
    end else begin
      lock1_q <= lockoutIn;
      lock2_q <= lock1_q;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [ADDR_W-1:0] unlockAddr(input logic [2:0] step);
    return (step == 3'h1 || step == 3'h4) ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
  endfunction : unlockAddr

  function automatic logic [DATA_W-1:0] unlockData(input logic [2:0] step, input logic [DATA_W-1:0] cmd);
    logic [DATA_W-1:0] res;
    res = CMD_UNLOCK1;
    if (step == 3'h1 || step == 3'h4) begin
      res = CMD_UNLOCK2;
    end else if (step == 3'h2) begin
      res = cmd;
    end
    return res;
  endfunction : unlockData

  // Wishbone slave: answers every access one cycle after it is seen and drops ack the next cycle.
  logic ack_q, ack_d;
  logic [31:0] datO_q, datO_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [SECT_N-1:0] mask_q, mask_d;
  logic wbTake, goStart;
  logic [1:0] opSel;
  logic [7:0] wbAddr;
  logic [31:0] statusWord;

  fesq_st_t st_q, st_d;
  logic [1:0] op_q, op_d;
  logic [2:0] step_q, step_d, sect_q, sect_d;
  logic first_q, first_d, recheck_q, recheck_d, expect_q, expect_d;
  logic done_q, done_d, fail_q, fail_d, late_q, late_d, lock_q, lock_d;
  logic req_q, req_d, isWr_q, isWr_d;
  logic [ADDR_W-1:0] cAddr_q, cAddr_d, pollAddr_q, pollAddr_d;
  logic [DATA_W-1:0] cData_q, cData_d, pollByte_q, pollByte_d, rdata_q, rdata_d;

  always_comb begin
    statusWord = '0;
    statusWord[ST_BUSY] = (st_q != ST_IDLE);
    statusWord[ST_DONE] = done_q;
    statusWord[ST_FAIL] = fail_q;
    statusWord[ST_LATE] = late_q;
    statusWord[ST_LOCK] = lock_q;
    statusWord[ST_WINOPEN] = !winExpired;
    statusWord[ST_POLL_LSB +: DATA_W] = pollByte_q;
    statusWord[ST_RDATA_LSB +: DATA_W] = rdata_q;
  end

  always_comb begin
    wbAddr = {adr_i[7:2], 2'b00};
    wbTake = cyc_i && stb_i && !ack_q;
    ack_d = wbTake;
    datO_d = datO_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    mask_d = mask_q;
    goStart = 1'b0;
    opSel = dat_i[CTRL_OP_LSB +: 2];
    if (wbTake && we_i) begin
      case (wbAddr)
        REG_CTRL: goStart = sel_i[0] && dat_i[CTRL_GO];
        REG_ADDR: addr_d = ADDR_W'(merge(32'(addr_q), dat_i, sel_i));
        REG_DATA: wdata_d = DATA_W'(merge(32'(wdata_q), dat_i, sel_i));
        REG_SECT: mask_d = SECT_N'(merge(32'(mask_q), dat_i, sel_i));
        default: goStart = 1'b0;
      endcase
    end else if (wbTake) begin
      case (wbAddr)
        REG_CTRL: datO_d = {29'h0, op_q, 1'b0};
        REG_ADDR: datO_d = 32'(addr_q);
        REG_DATA: datO_d = 32'(wdata_q);
        REG_SECT: datO_d = 32'(mask_q);
        REG_STATUS: datO_d = statusWord;
        default: datO_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      datO_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      mask_q <= '0;
    end else begin
      ack_q <= ack_d;
      datO_q <= datO_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      mask_q <= mask_d;
    end
  end

  // Sequencer. A cycle is issued when no request is outstanding and retired on the engine's done pulse.
  logic cycDone;
  assign cycDone = req_q && cycBus.done;

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    step_d = step_q;
    sect_d = sect_q;
    first_d = first_q;
    recheck_d = recheck_q;
    expect_d = expect_q;
    done_d = done_q;
    fail_d = fail_q;
    late_d = late_q;
    lock_d = lock_q;
    req_d = req_q;
    isWr_d = isWr_q;
    cAddr_d = cAddr_q;
    cData_d = cData_q;
    pollAddr_d = pollAddr_q;
    pollByte_d = pollByte_q;
    rdata_d = rdata_q;
    restart_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (goStart) begin
          op_d = opSel;
          {done_d, fail_d, late_d, lock_d, recheck_d} = '0;
          step_d = '0;
          sect_d = '0;
          first_d = 1'b1;
          if (lock2_q) begin
            lock_d = 1'b1;
            fail_d = 1'b1;
            done_d = 1'b1;
          end else if (opSel == OP_ERASE && mask_q == '0) begin
            fail_d = 1'b1;
            done_d = 1'b1;
          end else begin
            st_d = (opSel == OP_READ) ? ST_READ : ST_PREFIX;
          end
        end
      end
      ST_PREFIX, ST_RESET: begin
        if (!req_q) begin
          req_d = 1'b1;
          isWr_d = 1'b1;
          cAddr_d = unlockAddr(step_q);
          cData_d = unlockData(step_q, (st_q == ST_RESET || op_q == OP_RESET) ? CMD_RESET :
                    (op_q == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP);
        end else if (cycDone) begin
          req_d = 1'b0;
          step_d = step_q + 3'h1;
          if (st_q == ST_RESET || op_q == OP_RESET) begin
            if (step_q == PREFIX_LAST_SHORT) begin
              st_d = ST_IDLE;
              done_d = 1'b1;
            end
          end else if (op_q == OP_PROGRAM && step_q == PREFIX_LAST_SHORT) begin
            st_d = ST_PROG;
          end else if (step_q == PREFIX_LAST_ERASE) begin
            st_d = ST_SECTOR;
          end
        end
      end
      ST_PROG: begin
        if (!req_q) begin
          req_d = 1'b1;
          isWr_d = 1'b1;
          cAddr_d = addr_q;
          cData_d = wdata_q;
        end else if (cycDone) begin
          req_d = 1'b0;
          pollAddr_d = addr_q;
          expect_d = wdata_q[POLL_BIT];
          st_d = ST_POLL;
        end
      end
      ST_SECTOR: begin
        if (!req_q) begin
          if (!mask_q[sect_q]) begin
            if (sect_q == SECT_LAST) begin
              st_d = ST_POLL;
            end else begin
              sect_d = sect_q + 3'h1;
            end
          end else if (!first_q && winExpired) begin
            late_d = 1'b1;
            st_d = ST_POLL;
          end else begin
            req_d = 1'b1;
            isWr_d = 1'b1;
            cAddr_d = {sect_q, SECT_LSB'(0)};
            cData_d = CMD_SECTOR;
          end
        end else if (cycDone) begin
          req_d = 1'b0;
          restart_d = 1'b1;
          if (first_q) begin
            pollAddr_d = {sect_q, SECT_LSB'(0)};
          end
          first_d = 1'b0;
          expect_d = 1'b1;
          if (sect_q == SECT_LAST) begin
            st_d = ST_POLL;
          end else begin
            sect_d = sect_q + 3'h1;
          end
        end
      end
      ST_POLL: begin
        if (!req_q) begin
          req_d = 1'b1;
          isWr_d = 1'b0;
          cAddr_d = pollAddr_q;
        end else if (cycDone) begin
          req_d = 1'b0;
          pollByte_d = cycBus.rdata;
          if (cycBus.rdata[POLL_BIT] == expect_q) begin
            st_d = ST_IDLE;
            done_d = 1'b1;
          end else if (recheck_q) begin
            fail_d = 1'b1;
            step_d = '0;
            st_d = ST_RESET;
          end else if (cycBus.rdata[OVERTIME_BIT]) begin
            recheck_d = 1'b1;
          end
        end
      end
      ST_READ: begin
        if (!req_q) begin
          req_d = 1'b1;
          isWr_d = 1'b0;
          cAddr_d = addr_q;
        end else if (cycDone) begin
          req_d = 1'b0;
          rdata_d = cycBus.rdata;
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Lockout ends the sequence between cycles; the device itself falls back to read mode.
    if (st_q != ST_IDLE && lock2_q && !req_q) begin
      req_d = 1'b0;
      lock_d = 1'b1;
      fail_d = 1'b1;
      done_d = 1'b1;
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      op_q <= OP_RESET;
      step_q <= '0;
      sect_q <= '0;
      {first_q, recheck_q, expect_q, done_q, fail_q, late_q, lock_q, req_q, isWr_q, restart_q} <= '0;
      cAddr_q <= '0;
      cData_q <= '0;
      pollAddr_q <= '0;
      pollByte_q <= '0;
      rdata_q <= '0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      step_q <= step_d;
      sect_q <= sect_d;
      first_q <= first_d;
      recheck_q <= recheck_d;
      expect_q <= expect_d;
      done_q <= done_d;
      fail_q <= fail_d;
      late_q <= late_d;
      lock_q <= lock_d;
      req_q <= req_d;
      isWr_q <= isWr_d;
      restart_q <= restart_d;
      cAddr_q <= cAddr_d;
      cData_q <= cData_d;
      pollAddr_q <= pollAddr_d;
      pollByte_q <= pollByte_d;
      rdata_q <= rdata_d;
    end
  end

  assign cycBus.req = req_q;
  assign cycBus.isWrite = isWr_q;
  assign cycBus.addr = cAddr_q;
  assign cycBus.wdata = cData_q;
  assign dat_o = datO_q;
  assign ack_o = ack_q;
endmodule : fesq_sequencer
`default_nettype wire

/* File: rtl/fesq_window_timer.sv */
// Sector erase window timer: reloads on each accepted sector write and reports when the window has run out.
// Assumes restart is a one-cycle pulse given after the write strobe has risen.
`default_nettype none
module fesq_window_timer #(
  parameter int CYCLES = fesq_pkg::WINDOW_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic restart,
  output logic expired
);
  import fesq_pkg::*;
  // The guard of one whole write cycle covers the last write's strobe, hold and recovery and the next write's setup, so its falling strobe lands inside the window.
  localparam logic [WCNT_W-1:0] LOAD = WCNT_W'(CYCLES - WRITE_CYC);
  logic [WCNT_W-1:0] cnt_q, cnt_d;
  logic expired_q, expired_d;

  always_comb begin
    cnt_d = cnt_q;
    expired_d = expired_q;
    if (restart) begin
      cnt_d = LOAD;
      expired_d = 1'b0;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - WCNT_W'(1);
    end else begin
      expired_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= '0;
      expired_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      expired_q <= expired_d;
    end
  end

  assign expired = expired_q;
endmodule : fesq_window_timer
`default_nettype wire

/* File: tb/fesq_flash_model.sv */
// Behavioural model of the flash device: command decoder, erase window, status bits.
// Assumes window and algorithm times scaled down like the sequencer's window.
`default_nettype none
module fesq_flash_model #(
  parameter int WIN_NS = 800,
  parameter int BUSY_NS = 2000
) (
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [16:0] addr,
  input wire logic [7:0] dOut,
  input wire logic dOeN,
  input wire logic lock,
  input wire logic failMode,
  output logic [7:0] dIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  logic [7:0] bufMask = 0, lastErased = 0, pd = 0, lastV = 0;
  logic [16:0] la = 0;
  logic tog = 0, ovt = 0, armed = 0;
  int step = 0, busy = 0, writes = 0;
  time tLast = 0, tStart = 0;
  // A released bus shows the inverse of the last driven byte, so stale data never passes.
  always @* begin
    if (!dOeN) dIn = dOut;
    else if (ceN || oeN) dIn = ~lastV;
    else if (busy == 1) dIn = {~pd[7], tog, ovt, 5'h00};
    else if (busy == 2) dIn = {1'b0, tog, 6'h00};
    else if (busy == 3) dIn = {1'b0, tog, ovt, 5'h18};
    else dIn = mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hFF;
    if (!ceN && !oeN && dOeN) lastV = dIn;
  end
  always @(negedge oeN) if (!ceN) tog = ~tog;
  always @(negedge weN) if (!ceN && oeN) begin
    la = addr;
    armed = 1'b1;
    if (busy == 2) tLast = $time;
  end
  always @(posedge lock) begin
    busy = 0;
    step = 0;
    bufMask = 0;
  end
  always @(posedge weN) if (!ceN && oeN && armed && !lock && !(busy != 2 && busy != 0 && !ovt)) begin
    case (step)
      0: step = (la[14:0] == 15'h5555 && dIn == 8'hAA) ? 1 : 0;
      1: step = (la[14:0] == 15'h2AAA && dIn == 8'h55) ? 2 : 0;
      2: begin
        step = dIn == 8'hA0 ? 3 : dIn == 8'h80 ? 4 : 0;
        if (dIn == 8'hF0) {busy, ovt} = 0;
      end
      3: begin
        pd = dIn;
        mem[int'(la)] = (mem.exists(int'(la)) ? mem[int'(la)] : 8'hFF) & dIn;
        busy = 1;
        tStart = $time;
        step = 0;
      end
      4: step = dIn == 8'hAA ? 5 : 0;
      5: step = dIn == 8'h55 ? 6 : 0;
      default: if (dIn == 8'h30) begin
        bufMask[la[16:14]] = 1'b1;
        busy = 2;
        tLast = $time;
        step = 7;
      end else {busy, bufMask, step} = 0;
    endcase
  end
  always @(posedge weN) if (!ceN && oeN) writes++;
  always #20 begin
    if (busy == 2 && $time - tLast >= WIN_NS) begin
      lastErased = bufMask;
      busy = 3;
      tStart = $time;
    end
    if ((busy == 1 || busy == 3) && !ovt && $time - tStart >= BUSY_NS) begin
      if (failMode) ovt = 1'b1;
      else begin
        if (busy == 3) foreach (mem[a]) if (bufMask[a[16:14]]) mem[a] = 8'hFF;
        {busy, bufMask} = 0;
      end
    end
  end
endmodule : fesq_flash_model
`default_nettype wire

/* File: tb/fesq_sequencer_props.sv */
// Checker for the sequencer's bus answer and flash pin timing.
// Assumes the package write cycle of 5 setup, 13 strobe and 5 hold cycles.
`default_nettype none
module fesq_sequencer_props #(
  parameter int WINDOW_CYCLES = 200
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [16:0] flashAddr,
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN,
  input wire logic [7:0] flashDataOut,
  input wire logic flashDataOeN
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence weLow13;
    !flashWeN [*8] ##1 !flashWeN [*5];
  endsequence
  sequence holdAfterWe;
    (!flashCeN && !flashDataOeN) [*4] ##[1:4] flashCeN;
  endsequence
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  chk_write_gate: assert property (!flashWeN |-> !flashCeN && flashOeN) else $error("bad gating");
  chk_write_data: assert property (!flashWeN |-> !flashDataOeN) else $error("data not driven");
  chk_no_fight: assert property (!flashOeN |-> flashDataOeN) else $error("bus fight");
  chk_we_width: assert property ($fell(flashWeN) |-> weLow13 ##1 flashWeN) else $error("strobe width");
  chk_ce_setup: assert property ($fell(flashWeN) |-> !$past(flashCeN, 5)) else $error("select setup");
  chk_addr_hold: assert property (!flashWeN |-> $stable(flashAddr) && $stable(flashDataOut))
    else $error("address moved");
  chk_we_hold: assert property ($rose(flashWeN) |-> holdAfterWe) else $error("hold time");
endmodule : fesq_sequencer_props
bind fesq_sequencer fesq_sequencer_props #(.WINDOW_CYCLES(WINDOW_CYCLES)) i_fesq_sequencer_props (
  .clock(clock), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .flashAddr(flashAddr),
  .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN), .flashDataOut(flashDataOut),
  .flashDataOeN(flashDataOeN));
`default_nettype wire

/* File: tb/tb_top.sv */
// Testbench for the flash sequencer: Wishbone stimulus, device model behind the flash pins.
// Assumes the erase window is shortened to 200 cycles in both design and model.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fesq_pkg::*;
  logic clock = 0, rstn = 0, cyc = 0, stb = 0, we = 0, lock = 0, failMode = 0;
  logic [7:0] adr = 0, dOut, dIn;
  logic [31:0] datI = 0, datO;
  logic [3:0] sel = 0;
  logic ack, ceN, oeN, weN, dOeN;
  logic [16:0] fAddr;
  int failCount = 0, nTests = 0;
  initial forever #2 clock = ~clock;
  fesq_sequencer #(.WINDOW_CYCLES(200)) i_fesq_sequencer (.clock(clock), .rstn(rstn), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(datI), .sel_i(sel), .dat_o(datO), .ack_o(ack),
    .flashAddr(fAddr), .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashDataOut(dOut),
    .flashDataOeN(dOeN), .flashDataIn(dIn), .lockoutIn(lock));
  fesq_flash_model i_fesq_flash_model (.ceN(ceN), .oeN(oeN), .weN(weN), .addr(fAddr), .dOut(dOut),
    .dOeN(dOeN), .lock(lock), .failMode(failMode), .dIn(dIn));
  task automatic results;
    $display("Checks %0d, errors %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    {cyc, stb, we, adr, datI, sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = datO;
    {cyc, stb} <= 2'b00;
    if (n >= 64) begin
      failCount++;
      results();
    end
  endtask : wb
  task automatic runOp(input logic [1:0] op, output logic [31:0] s);
    int k;
    wb(1'b1, REG_CTRL, {29'h0, op, 1'b1}, s);
    // A write's answer carries stale read data, so status is always read at least once.
    k = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0, s);
      k++;
    end while (k < 2000 && s[ST_BUSY] !== 1'b0);
    if (s[ST_BUSY] !== 1'b0) begin
      failCount++;
      results();
    end
  endtask : runOp
  task automatic prog(input logic [16:0] a, input logic [7:0] d, output logic [31:0] s);
    wb(1'b1, REG_ADDR, {15'h0, a}, s);
    wb(1'b1, REG_DATA, {24'h0, d}, s);
    runOp(OP_PROGRAM, s);
  endtask : prog
  task automatic rdChk(input logic [16:0] a, input logic [7:0] e);
    logic [31:0] s;
    wb(1'b1, REG_ADDR, {15'h0, a}, s);
    runOp(OP_READ, s);
    chk(32'(s[ST_RDATA_LSB +: 8]), 32'(e));
  endtask : rdChk
  task automatic tProgram;
    logic [31:0] s;
    wb(1'b0, 8'h20, 32'h0, s);
    chk(s, 32'h0);
    prog(17'h04123, 8'h5A, s);
    chk(32'(s[2:0]), 32'h2);
    rdChk(17'h04123, 8'h5A);
  endtask : tProgram
  task automatic tErase;
    logic [31:0] s;
    prog(17'h1C010, 8'h00, s);
    wb(1'b1, REG_SECT, 32'h81, s);
    runOp(OP_ERASE, s);
    chk(32'(s[3:0]), 32'h2);
    chk(32'(i_fesq_flash_model.lastErased), 32'h81);
    rdChk(17'h1C010, 8'hFF);
    rdChk(17'h04123, 8'h5A);
  endtask : tErase
  task automatic tOvertime;
    logic [31:0] s;
    failMode <= 1'b1;
    prog(17'h00200, 8'h11, s);
    chk(32'(s[2:1]), 32'h3);
    chk(32'(i_fesq_flash_model.busy), 32'h0);
    failMode <= 1'b0;
  endtask : tOvertime
  task automatic tLockout;
    logic [31:0] s;
    int n;
    lock <= 1'b1;
    n = i_fesq_flash_model.writes;
    prog(17'h00300, 8'h22, s);
    chk(32'(s[ST_LOCK]), 32'h1);
    chk(32'(i_fesq_flash_model.writes - n), 32'h0);
    lock <= 1'b0;
  endtask : tLockout
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    tProgram();
    tErase();
    tOvertime();
    tLockout();
    results();
  end
endmodule : tb_top
`default_nettype wire
